// ---- lbcb_bcd_digit.sv ----
// One packed-BCD digit adder/subtractor with carry or borrow chaining.
// Assumes both operand digits are valid decimal digits.
`default_nettype none
module lbcb_bcd_digit (
   // Operands.
   input wire logic [3:0] a_in,
   input wire logic [3:0] b_in,
   input wire logic sub_in,
   input wire logic cy_in,
   // Results.
   output logic [3:0] d_out,
   output logic cy_out
);
   logic [4:0] raw;

   // Decimal correction by six on overflow or borrow.
   always_comb begin
      if (sub_in) begin
         raw = {1'b0, a_in} - {1'b0, b_in} - {4'h0, cy_in};
         cy_out = raw[4];
         d_out = raw[4] ? (raw[3:0] - 4'h6) : raw[3:0];
      end else begin
         raw = {1'b0, a_in} + {1'b0, b_in} + {4'h0, cy_in};
         cy_out = (raw > 5'h09);
         d_out = cy_out ? (raw[3:0] + 4'h6) : raw[3:0];
      end
   end
endmodule : lbcb_bcd_digit
`default_nettype wire

// ---- lbcb_exec.sv ----
// Decode and execute for logical, shift, bit, call and decimal operations.
// Assumes operands arrive ready with the instruction; extension word given.
`default_nettype none
// Summary of operation
// RULE1: AND source into destination, N Z from result, V C cleared, 3 cycles.
// RULE2: Exclusive-or into destination; indirect source to register 6 cycles.
// RULE3: OR into destination; absolute source form is two words, 9 cycles.
// RULE4: Right shifts and right rotates always clear overflow.
// RULE5: Bit ops on status low byte change only the selected bit.
// RULE6: Bit test takes 3 fewer cycles than other bit ops, marked forms.
// RULE7: Taken conditional absolute call pushes address plus 4, 12 cycles.
// RULE8: Absolute call return address is based on its own first word.
// RULE9: Short relative call displacement is signed magnitude.
// RULE10: Long relative call jumps to address plus 4 plus displacement.
// RULE11: Short relative call pushes address plus 2, jumps, 10 cycles.
// RULE12: Decimal add with carry updates Z and C; N and V undefined.
// RULE13: Decimal subtract with borrow writes decimal result back.
// RULE14: Size bit one selects word, zero selects byte.
// RULE15: Affected flags follow result; unaffected flags keep value.
// RULE16: Untaken conditional call leaves stack untouched, goes sequential.
// RULE17: Extension word fetched first; PC advances past every word.
module lbcb_exec
   import lbcb_pkg::*;
#(
   parameter int DW = 16
) (
   // Clock and reset.
   input wire logic clock_in,
   input wire logic rst_b_in,
   // Instruction and operands.
   input wire logic start_in,
   input wire logic [15:0] op_word_in,
   input wire logic [15:0] ext_word_in,
   input wire logic [15:0] pc_in,
   input wire logic [15:0] sp_in,
   input wire logic [15:0] src_in,
   input wire logic [15:0] dst_in,
   input wire logic [15:0] dst_addr_in,
   input wire logic dst_is_sr_in,
   input wire logic mem_src_in,
   input wire logic [15:0] sr_in,
   // Results.
   output logic busy_out,
   output logic done_out,
   output logic [15:0] result_out,
   output logic [15:0] sr_out,
   output logic [15:0] pc_out,
   output logic [15:0] sp_out,
   output lbcb_wr_t push_out,
   output logic [4:0] cycles_out
);
   typedef enum logic [1:0] {LBCB_IDLE, LBCB_RUN, LBCB_DONE} lbcb_state_t;

   lbcb_state_t state;
   logic [4:0] count;
   lbcb_op_t op;
   logic word_sz;
   logic [2:0] cls3;
   logic [1:0] cls2;
   logic [3:0] condition_select;
   logic condition_select_true;
   logic n, z, v, c;
   logic [15:0] next_res;
   logic next_n, next_z, next_v, next_c;
   logic [15:0] next_pc;
   logic [15:0] next_sp;
   logic next_push;
   logic [15:0] next_push_data;
   logic [4:0] next_cyc;
   logic [15:0] bcd_res;
   logic [4:0] bcd_cy;
   logic [15:0] sm_disp;
   logic [3:0] bsel;
   logic two_words;

   assign n = sr_in[LBCB_FLAG_N];
   assign z = sr_in[LBCB_FLAG_Z];
   assign v = sr_in[LBCB_FLAG_V];
   assign c = sr_in[LBCB_FLAG_C];
   assign word_sz = op_word_in[7]; // [RULE14]
   assign cls2 = op_word_in[6:5];
   assign cls3 = op_word_in[6:4];
   assign condition_select = op_word_in[11:8];
   assign bsel = op_word_in[3:0];
   assign two_words = (op_word_in[3:0] == 4'hf) || (op_word_in[3:0] == 4'h7);

   // Coarse decode of the operation class from the top nibble.
   always_comb begin
      case (op_word_in[15:12])
         4'h6, 4'h7: op = (cls2 == 2'h0) ? LBCB_OP_OR :
                          (cls2 == 2'h1) ? LBCB_OP_XOR :
                          (cls2 == 2'h2) ? LBCB_OP_AND : LBCB_OP_NONE;
         4'hb: op = LBCB_OP_SHIFT;
         4'h4: op = LBCB_OP_BIT;
         4'ha: op = LBCB_OP_DEC;
         4'hf: op = LBCB_OP_RELATIVE_CALL_S;
         4'h5: op = (op_word_in[7:0] == 8'h9f) ? LBCB_OP_RELATIVE_CALL_L :
                    (op_word_in[7:0] == 8'hbf) ? LBCB_OP_ABSOLUTE_CALL :
                    LBCB_OP_BIT;
         default: op = LBCB_OP_NONE;
      endcase
   end

   // Condition evaluation; bit 3 inverts the sense of the low three bits.
   always_comb begin
      logic t;
      t = 1'b0;
      case (condition_select[2:0])
         3'h0: t = z;
         3'h1: t = n;
         3'h2: t = c;
         3'h3: t = v;
         3'h4: t = n ^ v;
         3'h5: t = z | (n ^ v);
         3'h6: t = c | z;
         default: t = 1'b0;
      endcase
      condition_select_true = t ^ condition_select[3];
   end

   // Packed decimal digit chain; low byte only in byte mode.
   assign bcd_cy[0] = c & ~cls2[1]; // [RULE12] [RULE13]
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_bcd
         lbcb_bcd_digit u_dig (
            .a_in(dst_in[4*g+3:4*g]),
            .b_in(src_in[4*g+3:4*g]),
            .sub_in(cls2[0]),
            .cy_in(bcd_cy[g]),
            .d_out(bcd_res[4*g+3:4*g]),
            .cy_out(bcd_cy[g+1])
         );
      end
   endgenerate

   // Signed-magnitude displacement of the short call, sign in bit 11.
   // The top nibble is the opcode, so the magnitude is doubled to bytes.
   always_comb begin
      logic [15:0] mag;
      mag = {5'h00, op_word_in[10:0]} << 1;
      sm_disp = op_word_in[11] ? (16'h0000 - mag) : mag; // [RULE9]
   end

   // Execute: result, flags, program counter, stack and cycle count.
   always_comb begin
      logic [15:0] sh;
      logic b;
      logic [15:0] msk;
      next_res = dst_in;
      next_n = n;
      next_z = z;
      next_v = v;
      next_c = c; // [RULE15]
      next_pc = pc_in + LBCB_PC_STEP1;
      next_sp = sp_in;
      next_push = 1'b0;
      next_push_data = 16'h0000;
      next_cyc = LBCB_CYC_RR;
      sh = 16'h0000;
      b = 1'b0;
      msk = 16'h0001 << bsel;
      if (two_words) begin
         next_pc = pc_in + LBCB_PC_STEP2; // [RULE17]
      end
      case (op)
         LBCB_OP_AND, LBCB_OP_XOR, LBCB_OP_OR: begin
            if (op == LBCB_OP_AND) next_res = src_in & dst_in; // [RULE1]
            else if (op == LBCB_OP_XOR) next_res = src_in ^ dst_in; // [RULE2]
            else next_res = src_in | dst_in; // [RULE3]
            next_v = 1'b0; // [RULE1]
            next_c = 1'b0;
            if (op_word_in[4] == 1'b0) next_cyc = LBCB_CYC_RR;
            else if (op_word_in[3:0] == 4'hf) next_cyc = LBCB_CYC_ABS; // [RULE3]
            else if (op_word_in[3]) next_cyc = LBCB_CYC_ABS;
            else next_cyc = LBCB_CYC_IND; // [RULE2]
            if (op_word_in[15:12] == 4'h7) next_cyc = LBCB_CYC_MEMB;
            if (op_word_in[15:12] == 4'h6 && op_word_in[4] &&
                op_word_in[3]) begin
               next_pc = pc_in + LBCB_PC_STEP2; // [RULE17]
            end
         end
         LBCB_OP_SHIFT: begin
            case (cls3)
               3'h0: sh = {dst_in[0], dst_in[15:1]};
               3'h2: sh = {c, dst_in[15:1]};
               3'h4: sh = {dst_in[15], dst_in[15:1]};
               3'h6: sh = {1'b0, dst_in[15:1]};
               3'h1, 3'h3, 3'h5: sh = {dst_in[14:0], (cls3 == 3'h3) ? c :
                                    (cls3 == 3'h1) ? dst_in[15] : 1'b0};
               default: sh = dst_in;
            endcase
            if (!word_sz && !cls3[0]) begin
               sh[7] = (cls3 == 3'h6) ? 1'b0 : (cls3 == 3'h4) ? dst_in[7] :
                       (cls3 == 3'h2) ? c : dst_in[0];
            end
            next_res = sh;
            next_c = cls3[0] ? (word_sz ? dst_in[15] : dst_in[7]) : dst_in[0];
            if (!cls3[0]) next_v = 1'b0; // [RULE4]
            next_cyc = mem_src_in ? LBCB_CYC_IND + LBCB_CYC_RR : LBCB_CYC_RR;
         end
         LBCB_OP_BIT: begin
            b = |(dst_in & msk);
            next_c = b;
            next_z = ~b;
            case (cls3)
               3'h0: next_res = dst_in | msk;
               3'h1: next_res = dst_in ^ msk;
               3'h2: next_res = dst_in & ~msk;
               3'h7: next_res = c ? (dst_in | msk) : (dst_in & ~msk);
               default: next_res = dst_in;
            endcase
            next_v = 1'b0;
            next_cyc = mem_src_in ? LBCB_CYC_MEMB : LBCB_CYC_RR;
            if (mem_src_in && cls3 == 3'h3) begin
               next_cyc = LBCB_CYC_MEMB - LBCB_CYC_BIT_TEST_SAVE; // [RULE6]
            end
            if (dst_is_sr_in) begin
               next_res = (sr_in & ~msk) | (next_res & msk); // [RULE5]
               next_n = n;
               next_z = z;
               next_v = v;
               next_c = c;
            end
         end
         LBCB_OP_ABSOLUTE_CALL: begin
            if (condition_select == 4'hf || condition_select_true) begin
               next_sp = sp_in - LBCB_PC_STEP1; // [RULE7]
               next_push = 1'b1;
               next_push_data = pc_in + LBCB_PC_STEP2; // [RULE8]
               next_pc = ext_word_in;
               next_cyc = (condition_select == 4'hf) ? LBCB_CYC_ABS : LBCB_CYC_ABSOLUTE_CALL_T;
            end else begin
               next_cyc = LBCB_CYC_CALL_F; // [RULE16]
            end
         end
         LBCB_OP_RELATIVE_CALL_L: begin
            if (condition_select == 4'hf || condition_select_true) begin
               next_sp = sp_in - LBCB_PC_STEP1;
               next_push = 1'b1;
               next_push_data = pc_in + LBCB_PC_STEP2;
               next_pc = pc_in + LBCB_PC_STEP2 + ext_word_in; // [RULE10]
               next_cyc = (condition_select == 4'hf) ? LBCB_CYC_RELATIVE_CALL_L : LBCB_CYC_ABSOLUTE_CALL_T;
            end else begin
               next_cyc = LBCB_CYC_CALL_F; // [RULE16]
            end
         end
         LBCB_OP_RELATIVE_CALL_S: begin
            next_sp = sp_in - LBCB_PC_STEP1;
            next_push = 1'b1;
            next_push_data = pc_in + LBCB_PC_STEP1; // [RULE11]
            next_pc = pc_in + LBCB_PC_STEP2 + sm_disp;
            next_cyc = LBCB_CYC_RELATIVE_CALL_S;
         end
         LBCB_OP_DEC: begin
            next_res = bcd_res; // [RULE13]
            next_c = word_sz ? bcd_cy[4] : bcd_cy[2]; // [RULE12]
            next_n = 1'b0;
            next_v = 1'b0;
            next_cyc = op_word_in[4] ? (op_word_in[3] ? LBCB_CYC_ABS :
                       LBCB_CYC_IND) : LBCB_CYC_RR;
            if (op_word_in[4] && op_word_in[3]) begin
               next_pc = pc_in + LBCB_PC_STEP2; // [RULE17]
            end
         end
         default: next_pc = pc_in + LBCB_PC_STEP1;
      endcase
      if (!word_sz && op != LBCB_OP_ABSOLUTE_CALL && op != LBCB_OP_RELATIVE_CALL_S &&
          op != LBCB_OP_RELATIVE_CALL_L && !(op == LBCB_OP_BIT && dst_is_sr_in)) begin
         next_res = {dst_in[15:8], next_res[7:0]}; // [RULE14]
      end
      if (op == LBCB_OP_AND || op == LBCB_OP_XOR || op == LBCB_OP_OR ||
          op == LBCB_OP_SHIFT || op == LBCB_OP_DEC) begin
         next_z = word_sz ? (next_res == 16'h0000) : (next_res[7:0] == 8'h00);
         if (op != LBCB_OP_DEC) begin
            next_n = word_sz ? next_res[15] : next_res[7];
         end
      end
   end

   // Sequencer: load the count at start, then count down the cycle budget.
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state <= LBCB_IDLE;
         count <= 5'h00;
      end else begin
         case (state)
            LBCB_IDLE: if (start_in) begin
               state <= (next_cyc > 5'h01) ? LBCB_RUN : LBCB_DONE;
               count <= next_cyc - 5'h02;
            end
            LBCB_RUN: if (count == 5'h00) begin
               state <= LBCB_DONE;
            end else begin
               count <= count - 5'h01;
            end
            LBCB_DONE: state <= LBCB_IDLE;
            default: state <= LBCB_IDLE;
         endcase
      end
   end

   // Registered outputs; results visible from start until next start.
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         result_out <= 16'h0000;
         sr_out <= 16'h0000;
         pc_out <= 16'h0000;
         sp_out <= 16'h0000;
         push_out <= '0;
         cycles_out <= 5'h00;
      end else if (state == LBCB_IDLE && start_in) begin
         result_out <= next_res;
         sr_out <= (op == LBCB_OP_BIT && dst_is_sr_in) ? next_res :
                   {sr_in[15:4], next_n, next_z, next_v, next_c};
         pc_out <= next_pc;
         sp_out <= next_sp;
         push_out <= '{valid: next_push, addr: next_sp,
                       data: next_push_data, word: 1'b1};
         cycles_out <= next_cyc;
      end else begin
         push_out.valid <= 1'b0;
      end
   end

   // Status handshake outputs.
   always_ff @(posedge clock_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         busy_out <= 1'b0;
         done_out <= 1'b0;
      end else begin
         busy_out <= (state == LBCB_IDLE) ? start_in : (state == LBCB_RUN);
         done_out <= (state == LBCB_RUN && count == 5'h00) ||
                     (state == LBCB_IDLE && start_in && next_cyc <= 5'h01);
      end
   end

   // AND results clear carry and overflow.
   a_logic_clears_vc: assert property (@(posedge clock_in) // [RULE1]
      disable iff (!rst_b_in) (state == LBCB_IDLE && start_in &&
      op == LBCB_OP_AND) |=> (sr_out[1:0] == 2'b00))
      else $error("logic op left V or C set");
   a_right_shift_v: assert property (@(posedge clock_in) // [RULE4]
      disable iff (!rst_b_in) (state == LBCB_IDLE && start_in &&
      op == LBCB_OP_SHIFT && !cls3[0]) |=> !sr_out[LBCB_FLAG_V])
      else $error("right shift kept overflow");
   a_relative_call_s_push: assert property (@(posedge clock_in) // [RULE11]
      disable iff (!rst_b_in) (state == LBCB_IDLE && start_in &&
      op == LBCB_OP_RELATIVE_CALL_S) |=> push_out.valid &&
      push_out.data == $past(pc_in) + 16'h0002)
      else $error("short call pushed wrong return");
   a_absolute_call_ret: assert property (@(posedge clock_in) // [RULE8]
      disable iff (!rst_b_in) (state == LBCB_IDLE && start_in &&
      op == LBCB_OP_ABSOLUTE_CALL && condition_select_true) |=>
      push_out.data == $past(pc_in) + 16'h0004)
      else $error("absolute call return wrong");
   a_call_false: assert property (@(posedge clock_in) // [RULE16]
      disable iff (!rst_b_in) (state == LBCB_IDLE && start_in &&
      op == LBCB_OP_ABSOLUTE_CALL && condition_select != 4'hf && !condition_select_true) |=>
      !push_out.valid && sp_out == $past(sp_in) && cycles_out == 5'h06)
      else $error("untaken call touched stack");
   a_absolute_call_taken_cyc: assert property (@(posedge clock_in) // [RULE7]
      disable iff (!rst_b_in) (state == LBCB_IDLE && start_in &&
      op == LBCB_OP_ABSOLUTE_CALL && condition_select != 4'hf && condition_select_true) |=>
      cycles_out == 5'h0c && sp_out == $past(sp_in) - 16'h0002)
      else $error("taken call cycles or stack wrong");
   a_relative_call_l_target: assert property (@(posedge clock_in) // [RULE10]
      disable iff (!rst_b_in) (state == LBCB_IDLE && start_in &&
      op == LBCB_OP_RELATIVE_CALL_L && condition_select == 4'hf) |=>
      pc_out == $past(pc_in) + 16'h0004 + $past(ext_word_in) &&
      cycles_out == 5'h09)
      else $error("long relative call target wrong");
   // Done is launched at the second edge after start, seen one edge later.
   a_done_timing: assert property (@(posedge clock_in) // [RULE1]
      disable iff (!rst_b_in) (state == LBCB_IDLE && start_in &&
      next_cyc == 5'h03) |=> busy_out ##2 done_out)
      else $error("three cycle op not done in time");
   a_sr_bit_only: assert property (@(posedge clock_in) // [RULE5]
      disable iff (!rst_b_in) (state == LBCB_IDLE && start_in &&
      op == LBCB_OP_BIT && dst_is_sr_in) |=>
      ((sr_out ^ $past(sr_in)) & ~(16'h0001 << $past(bsel))) == 16'h0000)
      else $error("bit op on status changed other bits");
endmodule : lbcb_exec
`default_nettype wire

// ---- lbcb_exec_tb_top.sv ----
// Self-checking bench for the logic, bit, call and decimal execute block.
// Assumes one clock; the memory model supplies words and takes pushes.
`default_nettype none
module lbcb_exec_tb_top
   import lbcb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock_in = 1'b0;
   logic rst_b_in = 1'b0;
   logic start_in = 1'b0;
   logic dst_is_sr_in = 1'b0;
   logic mem_src_in = 1'b0;
   logic [15:0] pc_in = 16'h0040;
   logic [15:0] sp_in = 16'h0080;
   logic [15:0] src_in = 16'h0000;
   logic [15:0] dst_in = 16'h0000;
   logic [15:0] sr_in = 16'h0000;
   logic [15:0] op_word, ext_word, result_out, sr_out, pc_out, sp_out;
   logic busy_out, done_out;
   lbcb_wr_t push_out;
   logic [4:0] cycles_out;
   logic [7:0] pushes;
   int err_total = 0;
   int checks = 0;
   int ticks = 0;
   // Block under test and its memories.
   lbcb_exec uut (.clock_in(clock_in), .rst_b_in(rst_b_in),
      .start_in(start_in), .op_word_in(op_word), .ext_word_in(ext_word),
      .pc_in(pc_in), .sp_in(sp_in), .src_in(src_in), .dst_in(dst_in),
      .dst_addr_in(16'h0000), .dst_is_sr_in(dst_is_sr_in),
      .mem_src_in(mem_src_in), .sr_in(sr_in), .busy_out(busy_out),
      .done_out(done_out), .result_out(result_out), .sr_out(sr_out),
      .pc_out(pc_out), .sp_out(sp_out), .push_out(push_out),
      .cycles_out(cycles_out));
   lbcb_mem_model mem (.clock_in(clock_in), .pc_in(pc_in),
      .op_out(op_word), .ext_out(ext_word), .push_in(push_out),
      .pushes_out(pushes));
   // Clock at 100 MHz.
   initial forever #5 clock_in = ~clock_in;
   // A hung handshake must not stall the run forever.
   always @(posedge clock_in) begin
      ticks <= ticks + 1;
      if (ticks == 3000) begin
         err_total++;
         wrap_up();
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // Issues one instruction and times its completion against n cycles.
   task automatic iss(input logic [15:0] op, ext, s, d, sr,
         input logic m, r, input logic [4:0] n);
      int k;
      @(posedge clock_in);
      mem.prog[6'h20] <= op;
      mem.prog[6'h21] <= ext;
      start_in <= 1'b1;
      src_in <= s;
      dst_in <= d;
      sr_in <= sr;
      mem_src_in <= m;
      dst_is_sr_in <= r;
      @(posedge clock_in);
      start_in <= 1'b0;
      k = 0;
      @(negedge clock_in);
      while (done_out !== 1'b1 && k < 40) begin
         @(negedge clock_in);
         k++;
      end
      chk(16'(k), 16'(n) - 16'h0001);
      chk({11'h000, cycles_out}, {11'h000, n});
      chk({15'h0000, busy_out}, 16'h0001);
   endtask : iss
   task automatic t_logic();
      iss(16'h60c1, 16'h0000, 16'hf0f0, 16'h8f0f, 16'h1203, 1'b0, 1'b0,
         LBCB_CYC_RR);
      chk(result_out, 16'h8000);
      chk(sr_out, 16'h1208);
      chk(pc_out, pc_in + LBCB_PC_STEP1);
      iss(16'h6041, 16'h0000, 16'h0030, 16'hab0f, 16'h0008, 1'b0, 1'b0,
         LBCB_CYC_RR);
      chk(result_out, 16'hab00);
      chk(sr_out, 16'h0004);
      iss(16'h60b0, 16'h0000, 16'h1234, 16'h00ff, 16'h0000, 1'b1, 1'b0,
         LBCB_CYC_IND);
      chk(result_out, 16'h12cb);
      iss(16'h609f, 16'h0300, 16'h0a00, 16'h0055, 16'h0000, 1'b1, 1'b0,
         LBCB_CYC_ABS);
      chk(result_out, 16'h0a55);
      chk(pc_out, pc_in + LBCB_PC_STEP2);
      iss(16'h60d9, 16'h0010, 16'h00ff, 16'h0f0f, 16'h0000, 1'b1, 1'b0,
         LBCB_CYC_ABS);
      chk(result_out, 16'h000f);
      chk(pc_out, pc_in + LBCB_PC_STEP2);
   endtask : t_logic
   // Every right shift and rotate, with overflow set beforehand.
   task automatic t_shift();
      logic [2:0] c3;
      for (int i = 0; i < 4; i++) begin
         c3 = 3'(2 * i);
         iss(16'hb080 | {9'h000, c3, 4'h0}, 16'h0000, 16'h0000, 16'h8001,
            16'h0002, 1'b0, 1'b0, LBCB_CYC_RR);
         chk(sr_out & 16'h0002, 16'h0000);
      end
   endtask : t_shift
   task automatic t_bit();
      iss(16'h4f15, 16'h0000, 16'h0000, 16'ha5c9, 16'ha5c9, 1'b0, 1'b1,
         LBCB_CYC_RR);
      chk(sr_out, 16'ha5e9);
      iss(16'h4f26, 16'h0000, 16'h0000, 16'ha5c9, 16'ha5c9, 1'b0, 1'b1,
         LBCB_CYC_RR);
      chk(sr_out, 16'ha589);
      iss(16'h5f72, 16'h0200, 16'h0004, 16'h0004, 16'h0000, 1'b1, 1'b0,
         LBCB_CYC_MEMB);
      iss(16'h5f32, 16'h0200, 16'h0004, 16'h0004, 16'h0000, 1'b1, 1'b0,
         LBCB_CYC_MEMB - LBCB_CYC_BIT_TEST_SAVE);
      chk(sr_out & 16'h0001, 16'h0001);
   endtask : t_bit
   // Conditional absolute call on zero, taken and then not taken.
   task automatic t_absolute_call();
      logic [7:0] p;
      iss(16'h50bf, 16'h1230, 16'h0000, 16'h0000, 16'h0004, 1'b0, 1'b0,
         LBCB_CYC_ABSOLUTE_CALL_T);
      chk(pc_out, 16'h1230);
      chk(sp_out, sp_in - LBCB_PC_STEP1);
      chk(mem.stack[6'h3f], pc_in + LBCB_PC_STEP2);
      chk(sr_out, 16'h0004);
      p = pushes;
      iss(16'h50bf, 16'h1230, 16'h0000, 16'h0000, 16'h0000, 1'b0, 1'b0,
         LBCB_CYC_CALL_F);
      chk(pc_out, pc_in + LBCB_PC_STEP2);
      chk(sp_out, sp_in);
      chk({8'h00, pushes}, {8'h00, p});
   endtask : t_absolute_call
   // A negative short displacement tells the two number codings apart.
   task automatic t_relative_call();
      iss(16'hf805, 16'h0777, 16'h0000, 16'h0000, 16'h0000, 1'b0, 1'b0,
         LBCB_CYC_RELATIVE_CALL_S);
      chk(pc_out, pc_in + LBCB_PC_STEP2 - 16'h000a);
      chk(mem.stack[6'h3f], pc_in + LBCB_PC_STEP1);
      iss(16'h5f9f, 16'hfff0, 16'h0000, 16'h0000, 16'h0000, 1'b0, 1'b0,
         LBCB_CYC_RELATIVE_CALL_L);
      chk(pc_out, pc_in + LBCB_PC_STEP2 - 16'h0010);
      chk(mem.stack[6'h3f], pc_in + LBCB_PC_STEP2);
   endtask : t_relative_call
   task automatic t_dec();
      iss(16'ha081, 16'h0000, 16'h0199, 16'h0801, 16'h0001, 1'b0, 1'b0,
         LBCB_CYC_RR);
      chk(result_out, 16'h1001);
      chk(sr_out & 16'h0005, 16'h0000);
      iss(16'ha001, 16'h0000, 16'h0001, 16'h5599, 16'h0000, 1'b0, 1'b0,
         LBCB_CYC_RR);
      chk(result_out, 16'h5500);
      chk(sr_out & 16'h0005, 16'h0005);
      iss(16'ha0a1, 16'h0000, 16'h0001, 16'h1000, 16'h0001, 1'b0, 1'b0,
         LBCB_CYC_RR);
      chk(result_out, 16'h0998);
   endtask : t_dec
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : wrap_up
   // Reset for six cycles, then every scenario in turn.
   initial begin
      repeat (6) @(posedge clock_in);
      rst_b_in <= 1'b1;
      t_logic();
      t_shift();
      t_bit();
      t_absolute_call();
      t_relative_call();
      t_dec();
      wrap_up();
   end
endmodule : lbcb_exec_tb_top
`default_nettype wire

// ---- lbcb_mem_model.sv ----
// Partner model: program memory feeding the instruction words and data
// memory taking the stack pushes of the execute block.
// Assumes the bench loads the program words before each issue.
`default_nettype none
module lbcb_mem_model
   import lbcb_pkg::*;
(
   // Clock.
   input wire logic clock_in,
   // Fetch side.
   input wire logic [15:0] pc_in,
   output logic [15:0] op_out,
   output logic [15:0] ext_out,
   // Stack side.
   input wire lbcb_wr_t push_in,
   output logic [7:0] pushes_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] prog [0:63];
   logic [15:0] stack [0:63];
   logic [7:0] pushes = 8'h00;
   // Both words are offered at once, as the block takes them together.
   assign op_out = prog[pc_in[6:1]];
   assign ext_out = prog[pc_in[6:1] + 6'h01];
   // Pushes land as words; the count lets the bench see stray pushes.
   assign pushes_out = pushes;
   always @(posedge clock_in) begin
      if (push_in.valid === 1'b1) begin
         stack[push_in.addr[6:1]] <= push_in.data;
         pushes <= pushes + 8'h01;
      end
   end
endmodule : lbcb_mem_model
`default_nettype wire

// ---- lbcb_pkg.sv ----
// Package for the logic, bit, call and decimal execution block.
// Assumes a single 100 MHz core clock shared by all users of these types.
`default_nettype none
package lbcb_pkg;
   // Operation classes decoded from the operation word.
   typedef enum logic [3:0] {
      LBCB_OP_AND, LBCB_OP_XOR, LBCB_OP_OR, LBCB_OP_SHIFT, LBCB_OP_BIT,
      LBCB_OP_ABSOLUTE_CALL, LBCB_OP_RELATIVE_CALL_S, LBCB_OP_RELATIVE_CALL_L, LBCB_OP_DEC,
      LBCB_OP_NONE
   } lbcb_op_t;

   // Flag bit positions in the low byte of the status register.
   localparam int LBCB_FLAG_C = 0;
   localparam int LBCB_FLAG_V = 1;
   localparam int LBCB_FLAG_Z = 2;
   localparam int LBCB_FLAG_N = 3;

   // Cycle counts.
   localparam logic [4:0] LBCB_CYC_RR = 5'h03;
   localparam logic [4:0] LBCB_CYC_IND = 5'h06;
   localparam logic [4:0] LBCB_CYC_ABS = 5'h09;
   localparam logic [4:0] LBCB_CYC_MEMB = 5'h0c;
   localparam logic [4:0] LBCB_CYC_ABSOLUTE_CALL_T = 5'h0c;
   localparam logic [4:0] LBCB_CYC_CALL_F = 5'h06;
   localparam logic [4:0] LBCB_CYC_RELATIVE_CALL_S = 5'h0a;
   localparam logic [4:0] LBCB_CYC_RELATIVE_CALL_L = 5'h09;
   localparam logic [4:0] LBCB_CYC_BIT_TEST_SAVE = 5'h03;

   // Program-counter and stack steps in bytes.
   localparam logic [15:0] LBCB_PC_STEP1 = 16'h0002;
   localparam logic [15:0] LBCB_PC_STEP2 = 16'h0004;

   // Memory write request carried to data memory.
   typedef struct packed {
      logic        valid;
      logic [15:0] addr;
      logic [15:0] data;
      logic        word;
   } lbcb_wr_t;
endpackage : lbcb_pkg
`default_nettype wire
